// File: shared/mvb_pkg.sv
// shared constants and helpers for the process-data loopback pair
package mvb_pkg;
  localparam int          FC_W      = 4;
  localparam int          ADDR_W    = 12;
  localparam int          WORD_W    = 16;
  localparam int          NPORT     = 5;
  localparam int          MAX_WORDS = 16;
  localparam logic [3:0]  FC_16BIT  = 4'h0;
  localparam logic [3:0]  FC_MAX    = 4'h4;
  // port identifier field layout
  localparam int          FC_LSB    = 12;
  localparam int          ADDR_LSB  = 0;
  // default test port addresses and bit layout
  localparam logic [11:0] SINK_ADDR_DEF = 12'hd28;
  localparam logic [11:0] SRC_ADDR_DEF  = 12'hd20;
  localparam logic [11:0] SINK_BASE_DEF = 12'h001;
  localparam logic [11:0] SRC_BASE_DEF  = 12'h006;
  localparam int          SINK_BIT_DEF  = 3;
  localparam int          SRC_BIT_DEF   = 5;
  localparam logic [15:0] FIXED_WORD    = 16'h7f00;
  localparam logic [15:0] INVALID_WORD  = 16'hffff;
  localparam logic [15:0] WORD_RST      = 16'h0000;
  localparam logic        TEST_BIT_RST  = 1'b0;
  // timing
  localparam int          CLK_MHZ        = 250;
  localparam int          SETUP_TIME_US  = 2000;
  localparam int          SETUP_LIMIT_US = 511000;
  localparam int          SETUP_CYCLES   = SETUP_TIME_US * CLK_MHZ;
  localparam int          RSP_TIMEOUT    = 64;
  localparam int          CHECK_CYCLES   = 10;

  // words of 16 bits carried by a size code, zero if not process data
  function automatic logic [4:0] words_of(input logic [3:0] fc);
    words_of = (fc > FC_MAX) ? 5'h00 : 5'(5'h01 << fc);
  endfunction : words_of
endpackage : mvb_pkg

// File: shared/mvb_pd_if.sv
// frame-level link between bus administrator and device
`timescale 1ns/1ns
interface mvb_pd_if;
  logic        mf_valid;  // master frame: port identifier
  logic        mf_ready;
  logic [15:0] mf_id;
  logic        hd_valid;  // sink data words from the master side
  logic        hd_ready;
  logic [15:0] hd_data;
  logic        hd_last;
  logic        dh_valid;  // slave frame words from the device
  logic        dh_ready;
  logic [15:0] dh_data;
  logic        dh_last;
  modport dev  (input mf_valid, mf_id, hd_valid, hd_data, hd_last, dh_ready,
                output mf_ready, hd_ready, dh_valid, dh_data, dh_last);
  modport host (output mf_valid, mf_id, hd_valid, hd_data, hd_last,
                dh_ready, input mf_ready, hd_ready, dh_valid, dh_data,
                dh_last);
endinterface : mvb_pd_if

// File: hdl/mvb_pd_device.sv
// device end: test sink latch and loopback source ports
`timescale 1ns/1ns
module mvb_pd_device #(
  parameter bit          FULL      = 1'b0,
  parameter logic [3:0]  PORT_FC   = mvb_pkg::FC_16BIT,
  parameter logic [11:0] SINK_ADDR = mvb_pkg::SINK_ADDR_DEF,
  parameter logic [11:0] SRC_ADDR  = mvb_pkg::SRC_ADDR_DEF,
  parameter logic [11:0] SINK_BASE = mvb_pkg::SINK_BASE_DEF,
  parameter logic [11:0] SRC_BASE  = mvb_pkg::SRC_BASE_DEF,
  parameter int          SINK_BIT  = mvb_pkg::SINK_BIT_DEF,
  parameter int          SRC_BIT   = mvb_pkg::SRC_BIT_DEF,
  parameter int          SETUP_US  = mvb_pkg::SETUP_TIME_US
) (
  input  wire logic clk,
  input  wire logic rst,
  mvb_pd_if.dev     bus,
  input  wire logic src_invalid,
  output logic      test_bit
);
  import mvb_pkg::*;

  // one size code serves both simple ports, so they cannot differ
  initial begin
    if (PORT_FC > FC_MAX) $error("port size code out of range");
    if (SINK_BIT >= WORD_W || SRC_BIT >= WORD_W)
      $error("test bit outside first word");
    if (SETUP_US >= SETUP_LIMIT_US) $error("setup time too long");
  end

  typedef enum logic [1:0] {S_IDLE, S_RX, S_TX} dev_state_t;

  dev_state_t  st_ff, nxt_st;
  logic [4:0]  cnt_ff, nxt_cnt;
  logic [4:0]  len_ff, nxt_len;
  logic [2:0]  port_ff, nxt_port;
  logic        acc_ff, nxt_acc;
  logic        bit_ff, nxt_bit;
  logic        stage_ff, nxt_stage;
  logic [15:0] mem [NPORT][MAX_WORDS];

  // identifier decode
  wire logic [3:0]  id_fc   = bus.mf_id[FC_LSB +: FC_W];
  wire logic [11:0] id_addr = bus.mf_id[ADDR_LSB +: ADDR_W];
  wire logic [4:0]  id_len  = words_of(id_fc);
  wire logic        mf_take = bus.mf_valid & bus.mf_ready;

  logic       sink_hit;
  logic       src_hit;
  logic [2:0] sink_idx;
  logic [2:0] src_idx;

  // port lookup; the fuller variant maps port i to size code i
  always_comb begin
    sink_hit = 1'b0;
    src_hit  = 1'b0;
    sink_idx = 3'h0;
    src_idx  = 3'h0;
    if (FULL) begin
      for (int i = 0; i < NPORT; i++) begin
        if (id_addr == SINK_BASE + 12'(i)) begin
          sink_hit = 1'b1;
          sink_idx = 3'(i);
        end
        if (id_addr == SRC_BASE + 12'(i)) begin
          src_hit = 1'b1;
          src_idx = 3'(i);
        end
      end
    end else begin
      sink_hit = (id_addr == SINK_ADDR);
      src_hit  = (id_addr == SRC_ADDR);
    end
  end

  wire logic [3:0] sink_fc  = FULL ? 4'(sink_idx) : PORT_FC;
  wire logic [3:0] src_fc   = FULL ? 4'(src_idx) : PORT_FC;
  wire logic       sink_ok  = sink_hit & (id_fc == sink_fc);
  wire logic       src_ok   = src_hit & (id_fc == src_fc);

  // two-entry output buffer so a stalled reader loses no word
  logic [16:0] buf_ff [2];
  logic        wp_ff;
  logic        rp_ff;
  logic [1:0]  fill_ff;
  wire logic   buf_full = (fill_ff == 2'h2);
  wire logic   pop      = bus.dh_valid & bus.dh_ready;
  wire logic   push     = (st_ff == S_TX) & ~buf_full;

  // outgoing word: invalid pattern wins over everything
  wire logic        tx_last = (cnt_ff == len_ff - 5'h01);
  wire logic [15:0] bit_word = (cnt_ff == 5'h00) ?
                      16'(16'(bit_ff) << SRC_BIT) : WORD_RST;
  wire logic [15:0] tx_word =
    src_invalid ? INVALID_WORD :
    FULL ? mem[port_ff][cnt_ff[3:0]] : bit_word;

  wire logic rx_beat = (st_ff == S_RX) & bus.hd_valid;
  wire logic rx_end  = rx_beat & (cnt_ff == len_ff - 5'h01);

  assign bus.mf_ready = (st_ff == S_IDLE);
  assign bus.hd_ready = (st_ff == S_RX);
  assign bus.dh_valid = (fill_ff != 2'h0);
  assign bus.dh_data  = buf_ff[rp_ff][15:0];
  assign bus.dh_last  = buf_ff[rp_ff][16];
  assign test_bit     = bit_ff;

  // frame sequencing
  always_comb begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_len   = len_ff;
    nxt_port  = port_ff;
    nxt_acc   = acc_ff;
    nxt_bit   = bit_ff;
    nxt_stage = stage_ff;
    case (st_ff)
      S_IDLE: begin
        nxt_cnt = 5'h00;
        if (mf_take && sink_hit && id_len != 5'h00) begin
          // wrong size still drains its words, but nothing is kept
          nxt_st   = S_RX;
          nxt_len  = id_len;
          nxt_port = sink_idx;
          nxt_acc  = sink_ok;
        end else if (mf_take && src_ok) begin
          nxt_st   = S_TX;
          nxt_len  = id_len;
          nxt_port = src_idx;
        end
      end
      S_RX: begin
        if (rx_beat) begin
          nxt_cnt = cnt_ff + 5'h01;
          if (cnt_ff == 5'h00) begin
            nxt_stage = bus.hd_data[SINK_BIT];
          end
        end
        if (rx_end) begin
          nxt_st = S_IDLE;
          if (acc_ff && !FULL) begin
            // commit at frame end so a cut frame never lands
            nxt_bit = (cnt_ff == 5'h00) ?
                      bus.hd_data[SINK_BIT] : stage_ff;
          end
        end
      end
      S_TX: begin
        if (push) begin
          nxt_cnt = cnt_ff + 5'h01;
          if (tx_last) begin
            nxt_st = S_IDLE;
          end
        end
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff    <= S_IDLE;
      cnt_ff   <= 5'h00;
      len_ff   <= 5'h00;
      port_ff  <= 3'h0;
      acc_ff   <= 1'b0;
      bit_ff   <= TEST_BIT_RST;
      stage_ff <= TEST_BIT_RST;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      len_ff   <= nxt_len;
      port_ff  <= nxt_port;
      acc_ff   <= nxt_acc;
      bit_ff   <= nxt_bit;
      stage_ff <= nxt_stage;
    end
  end

  // sink words go straight to the equal-size source image
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < NPORT; p++) begin
        for (int w = 0; w < MAX_WORDS; w++) begin
          mem[p][w] <= WORD_RST;
        end
      end
    end else if (FULL && rx_beat && acc_ff) begin
      mem[port_ff][cnt_ff[3:0]] <= bus.hd_data;
    end
  end

  // buffer pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_ff     <= 1'b0;
      rp_ff     <= 1'b0;
      fill_ff   <= 2'h0;
      buf_ff[0] <= 17'h00000;
      buf_ff[1] <= 17'h00000;
    end else begin
      if (push) begin
        buf_ff[wp_ff] <= {tx_last, tx_word};
        wp_ff         <= ~wp_ff;
      end
      if (pop) begin
        rp_ff <= ~rp_ff;
      end
      fill_ff <= 2'(fill_ff + 2'(push) - 2'(pop));
    end
  end
endmodule : mvb_pd_device

// File: hdl/mvb_pd_master.sv
// master end: issues sink writes and source reads, checks replies
`timescale 1ns/1ns
module mvb_pd_master #(
  parameter int SETUP_WAIT = mvb_pkg::SETUP_CYCLES,
  parameter int TIMEOUT    = mvb_pkg::RSP_TIMEOUT,
  parameter int STEP_LEN   = mvb_pkg::CHECK_CYCLES,
  parameter int SINK_BIT   = mvb_pkg::SINK_BIT_DEF,
  parameter int SRC_BIT    = mvb_pkg::SRC_BIT_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  mvb_pd_if.host           bus,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_write,
  input  wire logic [3:0]  cmd_fc,
  input  wire logic [11:0] cmd_addr,
  input  wire logic        cmd_bit,
  input  wire logic        step_start,
  output logic             step_done,
  output logic             rsp_valid,
  output logic             rsp_silent,
  output logic             rsp_size_ok,
  output logic             rsp_bit,
  output logic [15:0]      rsp_word
);
  import mvb_pkg::*;

  initial begin
    if (SETUP_WAIT < 1 || TIMEOUT < 1 || STEP_LEN < 1)
      $error("counts must be at least one");
    if (SINK_BIT >= WORD_W || SRC_BIT >= WORD_W)
      $error("test bit outside first word");
  end

  typedef enum logic [2:0] {H_IDLE, H_MF, H_WR, H_RD} host_state_t;

  host_state_t st_ff;
  logic        wr_ff;
  logic [3:0]  fc_ff;
  logic [11:0] addr_ff;
  logic        tb_ff;
  logic [4:0]  cnt_ff;
  logic [31:0] gap_ff;
  logic [31:0] tmo_ff;
  logic [7:0]  cyc_ff;

  wire logic [4:0] len     = words_of(fc_ff);
  wire logic       take    = cmd_valid & cmd_ready;
  wire logic       wr_beat = bus.hd_valid & bus.hd_ready;
  wire logic       rd_beat = bus.dh_valid & bus.dh_ready;
  wire logic       wr_end  = wr_beat & bus.hd_last;
  wire logic       rd_end  = (rd_beat & bus.dh_last) |
                             (tmo_ff == 32'(TIMEOUT));

  // next read only after the declared setup time has passed
  assign cmd_ready    = (st_ff == H_IDLE) & (gap_ff == 32'h0);
  assign bus.mf_valid = (st_ff == H_MF);
  assign bus.mf_id    = {fc_ff, addr_ff};
  assign bus.hd_valid = (st_ff == H_WR);
  assign bus.hd_last  = (cnt_ff == len - 5'h01);
  // fixed part stays put, only the test bit moves
  assign bus.hd_data  = (cnt_ff == 5'h00) ?
    ((FIXED_WORD & ~16'(16'h0001 << SINK_BIT)) |
     16'(16'(tb_ff) << SINK_BIT)) : WORD_RST;
  assign bus.dh_ready = (st_ff == H_RD);

  // transfer sequencing; size code forwarded as given by the user
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff   <= H_IDLE;
      wr_ff   <= 1'b0;
      fc_ff   <= FC_16BIT;
      addr_ff <= 12'h000;
      tb_ff   <= 1'b0;
      cnt_ff  <= 5'h00;
    end else begin
      case (st_ff)
        H_IDLE: begin
          cnt_ff <= 5'h00;
          if (take) begin
            st_ff   <= H_MF;
            wr_ff   <= cmd_write;
            fc_ff   <= cmd_fc;
            addr_ff <= cmd_addr;
            tb_ff   <= cmd_bit;
          end
        end
        H_MF: if (bus.mf_ready) begin
          st_ff <= !wr_ff ? H_RD : (len == 5'h00) ? H_IDLE : H_WR;
        end
        H_WR: if (wr_beat) begin
          cnt_ff <= cnt_ff + 5'h01;
          if (wr_end) st_ff <= H_IDLE;
        end
        H_RD: begin
          if (rd_beat) cnt_ff <= cnt_ff + 5'h01;
          if (rd_end) st_ff <= H_IDLE;
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  // setup gap after each write that sends data words, reply timeout during reads
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_ff <= 32'h0;
      tmo_ff <= 32'h0;
    end else begin
      if (st_ff == H_WR && wr_end) gap_ff <= 32'(SETUP_WAIT);
      else if (gap_ff != 32'h0) gap_ff <= gap_ff - 32'h1;
      tmo_ff <= (st_ff == H_RD && !rd_end) ? tmo_ff + 32'h1 : 32'h0;
    end
  end

  // reply capture and per-step cycle count
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid   <= 1'b0;
      rsp_silent  <= 1'b0;
      rsp_size_ok <= 1'b0;
      rsp_bit     <= 1'b0;
      rsp_word    <= WORD_RST;
      cyc_ff      <= 8'h00;
      step_done   <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      step_done <= 1'b0;
      if (st_ff == H_RD && rd_beat && cnt_ff == 5'h00) begin
        rsp_word <= bus.dh_data;
        rsp_bit  <= bus.dh_data[SRC_BIT];
      end
      if (st_ff == H_RD && rd_end) begin
        rsp_valid   <= 1'b1;
        rsp_silent  <= (cnt_ff == 5'h00) & ~rd_beat;
        rsp_size_ok <= (cnt_ff + 5'(rd_beat)) == len;
      end
      // a read closes one write/read cycle of the running step
      if (step_start) begin
        cyc_ff <= 8'h00;
      end else if (st_ff == H_RD && rd_end) begin
        if (cyc_ff == 8'(STEP_LEN - 1)) begin
          cyc_ff    <= 8'h00;
          step_done <= 1'b1;
        end else begin
          cyc_ff <= cyc_ff + 8'h01;
        end
      end
    end
  end
endmodule : mvb_pd_master

// File: tb/mvb_pd_monitor.sv
// checker for the frame link between the master and device ends
`timescale 1ns/1ns
module mvb_pd_monitor
  import mvb_pkg::*;
(
  input logic        clk,
  input logic        rst,
  input logic        mf_valid,
  input logic        mf_ready,
  input logic [15:0] mf_id,
  input logic        hd_valid,
  input logic        hd_ready,
  input logic [15:0] hd_data,
  input logic        hd_last,
  input logic        dh_valid,
  input logic        dh_ready,
  input logic [15:0] dh_data,
  input logic        dh_last,
  input logic        src_invalid,
  input logic        test_bit
);
  logic take;
  logic sink_ok_ff;
  logic sink_bad_ff;
  logic nxt_sink_ok;
  logic nxt_sink_bad;

  // kind of sink frame in flight, held until the next identifier
  assign take         = mf_valid && mf_ready;
  assign nxt_sink_ok  = take ? (mf_id == {FC_16BIT, SINK_ADDR_DEF})
                             : sink_ok_ff;
  assign nxt_sink_bad = take ? (mf_id[11:0] == SINK_ADDR_DEF &&
                                mf_id[15:12] != FC_16BIT) : sink_bad_ff;

  // cleared on reset so no stale frame kind survives
  always_ff @(posedge clk) begin
    if (rst) begin
      sink_ok_ff  <= 1'b0;
      sink_bad_ff <= 1'b0;
    end else begin
      sink_ok_ff  <= nxt_sink_ok;
      sink_bad_ff <= nxt_sink_bad;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence src_take;
    take && mf_id == {FC_16BIT, SRC_ADDR_DEF};
  endsequence
  sequence foreign_take;
    take && mf_id[11:0] != SINK_ADDR_DEF &&
      mf_id != {FC_16BIT, SRC_ADDR_DEF};
  endsequence

  id_hold_a: assert property (mf_valid && !mf_ready |=>
    mf_valid && $stable(mf_id)) else $error("identifier dropped");
  word_hold_a: assert property (dh_valid && !dh_ready |=> dh_valid &&
    $stable(dh_data) && $stable(dh_last)) else $error("word dropped");
  one_word_a: assert property (src_take |-> ##[2:16]
    (dh_valid && dh_last)) else $error("no single word answer");
  silent_a: assert property (foreign_take |=> !dh_valid [*8])
    else $error("answer on foreign port");
  invalid_word_a: assert property (dh_valid && src_invalid |->
    dh_data == INVALID_WORD) else $error("invalid data wrong");
  echo_word_a: assert property (dh_valid && !src_invalid |->
    dh_data == (16'(test_bit) << SRC_BIT_DEF)) else $error("echo wrong");
  latch_bit_a: assert property (hd_valid && hd_ready && sink_ok_ff |=>
    test_bit == $past(hd_data[SINK_BIT_DEF])) else $error("not latched");
  keep_bit_a: assert property (sink_bad_ff |=> $stable(test_bit))
    else $error("bit changed on wrong size");
  fixed_bits_a: assert property (hd_valid && sink_ok_ff |->
    (hd_data & ~(16'h0001 << SINK_BIT_DEF)) == FIXED_WORD)
    else $error("masked bits moved");
  reset_state_a: assert property ($fell(rst) |->
    mf_ready && !test_bit && !dh_valid) else $error("reset state wrong");
endmodule : mvb_pd_monitor

// File: tb/mvb_process_data_loopback_tb_top.sv
// testbench: master and device ends joined across the frame link
`timescale 1ns/1ns
module mvb_process_data_loopback_tb_top;
  import mvb_pkg::*;
  localparam int LIMIT = 20000;  // whole plan needs about 2000 cycles
  logic        clk;
  logic        rst;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_write;
  logic [3:0]  cmd_fc;
  logic [11:0] cmd_addr;
  logic        cmd_bit;
  logic        step_start;
  logic        step_done;
  logic        rsp_valid;
  logic        rsp_silent;
  logic        rsp_size_ok;
  logic        rsp_bit;
  logic [15:0] rsp_word;
  logic        src_invalid;
  logic        test_bit;
  int          steps_seen;
  logic        b;
  int          fails;
  int          tests_run;
  int          cycles;

  mvb_pd_if bus ();
  mvb_pd_device mvb_pd_device_inst (.clk(clk), .rst(rst), .bus(bus),
    .src_invalid(src_invalid), .test_bit(test_bit));
  // short setup wait keeps the run brief
  mvb_pd_master #(.SETUP_WAIT(20)) mvb_pd_master_inst (.clk(clk),
    .rst(rst), .bus(bus), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_fc(cmd_fc), .cmd_addr(cmd_addr),
    .cmd_bit(cmd_bit), .step_start(step_start), .step_done(step_done),
    .rsp_valid(rsp_valid), .rsp_silent(rsp_silent),
    .rsp_size_ok(rsp_size_ok), .rsp_bit(rsp_bit), .rsp_word(rsp_word));
  mvb_pd_monitor mvb_pd_monitor_inst (.clk(clk), .rst(rst),
    .mf_valid(bus.mf_valid), .mf_ready(bus.mf_ready), .mf_id(bus.mf_id),
    .hd_valid(bus.hd_valid), .hd_ready(bus.hd_ready),
    .hd_data(bus.hd_data), .hd_last(bus.hd_last),
    .dh_valid(bus.dh_valid), .dh_ready(bus.dh_ready),
    .dh_data(bus.dh_data), .dh_last(bus.dh_last),
    .src_invalid(src_invalid), .test_bit(test_bit));

  // free-running clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic final_report;
    $display("counts: %0d checks, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // hold the command until the edge that samples cmd_ready high
  task automatic send(input logic wr, input logic [3:0] fc,
                      input logic [11:0] addr, input logic tb);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_fc    <= fc;
    cmd_addr  <= addr;
    cmd_bit   <= tb;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 200);
    cmd_valid <= 1'b0;
    if (n >= 200) check(1'b0, 1'b1, "command not taken");
  endtask : send

  // read waits for the one-cycle completion pulse, bounded
  task automatic read(input logic [3:0] fc, input logic [11:0] addr);
    int n;
    n = 0;
    send(1'b0, fc, addr, 1'b0);
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 200);
    if (n >= 200) check(1'b0, 1'b1, "read never completed");
  endtask : read

  // step completion is a pulse, so every one is counted here
  always @(posedge clk) begin
    if (rst) steps_seen <= 0;
    else if (step_done === 1'b1) steps_seen <= steps_seen + 1;
  end

  // hang guard; one writer only, cleared by the bench reset
  always @(posedge clk) begin
    if (rst) cycles <= 0;
    else cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      $display("FAIL t=%0t run exceeded cycle ceiling", $time);
      final_report();
    end
  end

  initial begin
    {cmd_valid, cmd_write, cmd_bit, step_start, src_invalid} = 5'h00;
    cmd_fc    = 4'h0;
    cmd_addr  = 12'h000;
    rst       = 1'b1;
    fails     = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    check(test_bit, TEST_BIT_RST, "bit after reset");
    read(FC_16BIT, SRC_ADDR_DEF);
    check(rsp_word, WORD_RST, "first echo");
    $display("test reset done");
    // loopback: bit alternates, every read must echo the last write
    @(posedge clk);
    step_start <= 1'b1;
    @(posedge clk);
    step_start <= 1'b0;
    for (int i = 0; i < CHECK_CYCLES; i++) begin
      b = i[0];
      send(1'b1, FC_16BIT, SINK_ADDR_DEF, b);
      read(FC_16BIT, SRC_ADDR_DEF);
      check(test_bit, b, "latched bit");
      check(rsp_size_ok, 1'b1, "echo size");
      check(rsp_word, 16'(b) << SRC_BIT_DEF, "echo word");
      check(rsp_bit, b, "echo bit");
    end
    // the step pulse is counted one edge after the last read returns
    @(posedge clk);
    check(16'(steps_seen), 16'h0001, "step of ten reads");
    $display("test loopback done");
    // wrong sizes on the sink must leave the bit alone, ten cycles
    for (int k = 0; k < CHECK_CYCLES; k++) begin
      send(1'b1, 4'(k % 4 + 1), SINK_ADDR_DEF, ~b);
      read(FC_16BIT, SRC_ADDR_DEF);
      check(test_bit, b, "bit kept");
      check(rsp_size_ok, 1'b1, "kept size");
      check(rsp_word, 16'(b) << SRC_BIT_DEF, "old echo");
    end
    @(posedge clk);
    check(16'(steps_seen), 16'h0002, "mismatch step");
    $display("test size mismatch done");
    // invalidated source answers full size with invalid data
    @(posedge clk);
    src_invalid <= 1'b1;
    for (int k = 0; k < CHECK_CYCLES; k++) begin
      send(1'b1, FC_16BIT, SINK_ADDR_DEF, k[0]);
      read(FC_16BIT, SRC_ADDR_DEF);
      check(rsp_size_ok, 1'b1, "invalid size");
      check(rsp_word, INVALID_WORD, "invalid word");
    end
    @(posedge clk);
    check(16'(steps_seen), 16'h0003, "invalidate step");
    src_invalid <= 1'b0;
    $display("test invalidate done");
    // other sizes of the source, all sizes of an unpublished port
    for (int k = 0; k < 9; k++) begin
      if (k < 4) read(4'(k + 1), SRC_ADDR_DEF);
      else read(4'(k - 4), 12'h019);
      check(rsp_silent, 1'b1, "silence");
    end
    $display("test silence done");
    final_report();
  end
endmodule : mvb_process_data_loopback_tb_top
